// [rtl/fabric_pkg.sv]
// How it works
// - Program reads return on 16-bit bus.
// - Program memory addressed by 21-bit bus.
// - Program writes use low write-bus half.
// - Primary reads return on 32-bit bus.
// - Primary writes take 32-bit write bus.
// - Primary address 24 bits, all sizes.
// - Dual read returns on 16-bit bus.
// - Secondary address 24 bits, words only.
// - Peripheral bus 16-bit, no wait cycles.
// - Peripheral data via core write/read buses.
// - Byte accesses force address MSB zero.
// - Primary RAM port 32, others 16.
// - Flash array accessed directly, control via peripherals.
// - Timer channel issues periodic conversion starts.
// - Alternate mode routes reload to timer.
// - Active-low asserted low, active-high high.
// - Data RAM serves two reads per cycle.
package fabric_pkg;

    // Bus widths.
    localparam int PROG_AW = 21;
    localparam int DATA_AW = 24;
    localparam int WIDE_DW = 32;
    localparam int NARROW_DW = 16;
    localparam int BE_W = 4;

    // Region decode on the upper primary address bits.
    localparam int REGION_LSB = 12;
    localparam logic [11:0] PERIPH_REGION = 12'h00F;
    localparam logic [11:0] FLASH_REGION = 12'h004;

    // Byte enables per access size.
    localparam logic [3:0] BE_LONG = 4'hF;
    localparam logic [3:0] BE_WORD = 4'h3;
    localparam logic [3:0] BE_BYTE_LO = 4'h1;
    localparam logic [3:0] BE_BYTE_HI = 4'h2;
    localparam logic [3:0] BE_NONE = 4'h0;

    // Reset values.
    localparam logic [DATA_AW-1:0] ADDR_RST = 24'h000000;
    localparam logic [PROG_AW-1:0] PADDR_RST = 21'h000000;
    localparam logic [WIDE_DW-1:0] WIDE_RST = 32'h00000000;
    localparam logic [NARROW_DW-1:0] NARROW_RST = 16'h0000;

    // Access size encoding on the core request port.
    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_LONG
    } size_t;

    // Target selected by the primary address decode.
    typedef enum logic [1:0] {
        TGT_RAM,
        TGT_FLASH,
        TGT_PERIPH
    } tgt_t;

endpackage

// [rtl/read_return_reg.sv]
`timescale 1ns/10ps
`default_nettype none
module read_return_reg
    import fabric_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Capture side.
    input wire logic cap_i,
    input wire logic [W-1:0] data_i,
    // Returned data.
    output logic [W-1:0] data_o,
    output logic valid_o
);

    typedef struct packed {
        logic [W-1:0] data;
        logic valid;
    } ret_t;

    ret_t st_r;
    ret_t st_nxt;

    // Data holds until the next capture; valid is a one-cycle pulse.
    always_comb begin
        st_nxt = st_r;
        st_nxt.valid = cap_i;
        if (cap_i) begin
            st_nxt.data = data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign data_o = st_r.data;
    assign valid_o = st_r.valid;

endmodule
`default_nettype wire

// [rtl/core_system_bus_fabric.sv]
`timescale 1ns/10ps
`default_nettype none
module core_system_bus_fabric
    import fabric_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Core program request.
    input wire logic [PROG_AW-1:0] prog_addr_i,
    input wire logic prog_rd_i,
    input wire logic prog_wr_i,
    // Core primary data request.
    input wire logic [DATA_AW-1:0] primary_data_addr_bus_i,
    input wire logic data_rd_i,
    input wire logic data_wr_i,
    input wire logic [1:0] data_size_i,
    input wire logic [WIDE_DW-1:0] core_wdata_i,
    // Core secondary read request.
    input wire logic [DATA_AW-1:0] second_addr_bus_i,
    input wire logic sec_rd_i,
    // Core answers.
    output logic [NARROW_DW-1:0] prog_rdata_o,
    output logic prog_rvalid_o,
    output logic [WIDE_DW-1:0] core_rdata_o,
    output logic core_rvalid_o,
    output logic [NARROW_DW-1:0] second_read_bus_o,
    output logic second_rvalid_o,
    // Program memory port.
    output logic [PROG_AW-1:0] pmem_addr_o,
    output logic pmem_rd_o,
    output logic pmem_wr_o,
    output logic [NARROW_DW-1:0] pmem_wdata_o,
    input wire logic [NARROW_DW-1:0] pmem_rdata_i,
    // Data RAM primary port.
    output logic [DATA_AW-1:0] ram_addr_o,
    output logic ram_rd_o,
    output logic ram_wr_o,
    output logic [BE_W-1:0] ram_be_o,
    output logic [WIDE_DW-1:0] ram_wdata_o,
    input wire logic [WIDE_DW-1:0] ram_rdata_i,
    // Data RAM secondary port.
    output logic [DATA_AW-1:0] ram2_addr_o,
    output logic ram2_rd_o,
    input wire logic [NARROW_DW-1:0] ram2_rdata_i,
    // Flash module array port.
    output logic [DATA_AW-1:0] flash_module_addr_o,
    output logic flash_module_rd_n_o,
    output logic flash_module_wr_n_o,
    output logic [NARROW_DW-1:0] flash_module_wdata_o,
    input wire logic [NARROW_DW-1:0] flash_module_rdata_i,
    // Peripheral bus.
    output logic [DATA_AW-1:0] peripheral_bus_addr_o,
    output logic peripheral_bus_rd_o,
    output logic peripheral_bus_wr_o,
    output logic [NARROW_DW-1:0] peripheral_bus_wdata_o,
    input wire logic [NARROW_DW-1:0] peripheral_bus_rdata_i,
    // Conversion trigger routing.
    input wire logic alt_trigger_mode_i,
    input wire logic pwm_reload_i,
    input wire logic timer_chan_out_i,
    output logic timer_chan_in_o,
    output logic adc_start_o
);

    typedef struct packed {
        logic [PROG_AW-1:0] pmem_addr;
        logic pmem_rd;
        logic pmem_wr;
        logic [NARROW_DW-1:0] pmem_wdata;
        logic prog_data_due;
        logic [DATA_AW-1:0] ram_addr;
        logic ram_rd;
        logic ram_wr;
        logic [BE_W-1:0] ram_be;
        logic [WIDE_DW-1:0] ram_wdata;
        logic [DATA_AW-1:0] ram2_addr;
        logic ram2_rd;
        logic sec_data_due;
        logic [DATA_AW-1:0] fl_addr;
        logic fl_rd_n;
        logic fl_wr_n;
        logic [NARROW_DW-1:0] fl_wdata;
        logic [DATA_AW-1:0] pb_addr;
        logic pb_rd;
        logic pb_wr;
        logic [NARROW_DW-1:0] pb_wdata;
        logic rd_strobe;
        logic rd_due;
        tgt_t rd_tgt;
        size_t rd_size;
        logic [1:0] rd_lane;
        tgt_t due_tgt;
        size_t due_size;
        logic [1:0] due_lane;
        logic [WIDE_DW-1:0] core_rdata;
        logic core_rvalid;
        logic timer_in;
        logic adc_start;
    } fab_t;

    fab_t st_r;
    fab_t st_nxt;

    // Decode helpers for the current primary request.
    size_t req_size;
    tgt_t req_tgt;
    logic [DATA_AW-1:0] eff_addr;
    logic [DATA_AW-1:0] word_addr;
    logic [BE_W-1:0] req_be;
    logic [1:0] req_lane;

    // Secondary data return and program data return.
    logic [NARROW_DW-1:0] sec_ret_data;
    logic sec_ret_valid;
    logic [NARROW_DW-1:0] prog_ret_data;
    logic prog_ret_valid;

    // Byte accesses address bytes, word and long accesses address words.
    always_comb begin
        req_size = size_t'(data_size_i);
        eff_addr = primary_data_addr_bus_i;
        if (req_size == SZ_BYTE) begin
            eff_addr[DATA_AW-1] = 1'b0;
        end
        case (req_size)
            SZ_BYTE: begin
                word_addr = {1'b0, eff_addr[DATA_AW-1:1]};
                req_be = eff_addr[0] ? BE_BYTE_HI : BE_BYTE_LO;
                req_lane = {1'b0, eff_addr[0]};
            end
            SZ_LONG: begin
                word_addr = eff_addr;
                req_be = BE_LONG;
                req_lane = 2'h0;
            end
            default: begin
                word_addr = eff_addr;
                req_be = BE_WORD;
                req_lane = 2'h0;
            end
        endcase
        if (word_addr[DATA_AW-1:REGION_LSB] == PERIPH_REGION) begin
            req_tgt = TGT_PERIPH;
        end else if (word_addr[DATA_AW-1:REGION_LSB] == FLASH_REGION) begin
            req_tgt = TGT_FLASH;
        end else begin
            req_tgt = TGT_RAM;
        end
    end

    // Next state: target strobes last one cycle, read data is taken the cycle
    // after the strobe so every target, peripherals included, has the same
    // fixed latency and the core never waits.
    always_comb begin
        st_nxt = st_r;

        st_nxt.pmem_addr = (prog_rd_i || prog_wr_i) ? prog_addr_i : st_r.pmem_addr;
        st_nxt.pmem_rd = prog_rd_i && !prog_wr_i;
        st_nxt.pmem_wr = prog_wr_i;
        if (prog_wr_i) begin
            st_nxt.pmem_wdata = core_wdata_i[NARROW_DW-1:0];
        end
        st_nxt.prog_data_due = st_r.pmem_rd;

        // Primary strobes default to idle; a write wins over a read.
        st_nxt.ram_rd = 1'b0;
        st_nxt.ram_wr = 1'b0;
        st_nxt.fl_rd_n = 1'b1;
        st_nxt.fl_wr_n = 1'b1;
        st_nxt.pb_rd = 1'b0;
        st_nxt.pb_wr = 1'b0;
        st_nxt.rd_strobe = 1'b0;

        if (data_wr_i || data_rd_i) begin
            st_nxt.rd_strobe = !data_wr_i;
            st_nxt.rd_tgt = req_tgt;
            st_nxt.rd_size = req_size;
            st_nxt.rd_lane = req_lane;
            case (req_tgt)
                TGT_PERIPH: begin
                    st_nxt.pb_addr = word_addr;
                    st_nxt.pb_rd = !data_wr_i;
                    st_nxt.pb_wr = data_wr_i;
                    if (data_wr_i) begin
                        st_nxt.pb_wdata = (req_size == SZ_BYTE) ?
                            {2{core_wdata_i[7:0]}} : core_wdata_i[NARROW_DW-1:0];
                    end
                end
                TGT_FLASH: begin
                    st_nxt.fl_addr = word_addr;
                    st_nxt.fl_rd_n = data_wr_i;
                    st_nxt.fl_wr_n = !data_wr_i;
                    if (data_wr_i) begin
                        st_nxt.fl_wdata = (req_size == SZ_BYTE) ?
                            {2{core_wdata_i[7:0]}} : core_wdata_i[NARROW_DW-1:0];
                    end
                end
                default: begin
                    st_nxt.ram_addr = word_addr;
                    st_nxt.ram_rd = !data_wr_i;
                    st_nxt.ram_wr = data_wr_i;
                    st_nxt.ram_be = req_be;
                    if (data_wr_i) begin
                        case (req_size)
                            SZ_BYTE: st_nxt.ram_wdata = {4{core_wdata_i[7:0]}};
                            SZ_LONG: st_nxt.ram_wdata = core_wdata_i;
                            default: st_nxt.ram_wdata = {2{core_wdata_i[15:0]}};
                        endcase
                    end
                end
            endcase
        end
        st_nxt.rd_due = st_r.rd_strobe;
        // Read attributes travel with the read, so a request taken one cycle
        // later, read or write, cannot change how this answer is formatted.
        st_nxt.due_tgt = st_r.rd_tgt;
        st_nxt.due_size = st_r.rd_size;
        st_nxt.due_lane = st_r.rd_lane;

        st_nxt.core_rvalid = st_r.rd_due;
        if (st_r.rd_due) begin
            case (st_r.due_tgt)
                TGT_PERIPH: begin
                    st_nxt.core_rdata = {16'h0000, peripheral_bus_rdata_i};
                    if (st_r.due_size == SZ_BYTE) begin
                        st_nxt.core_rdata = {24'h000000, st_r.due_lane[0] ?
                            peripheral_bus_rdata_i[15:8] : peripheral_bus_rdata_i[7:0]};
                    end
                end
                TGT_FLASH: begin
                    st_nxt.core_rdata = {16'h0000, flash_module_rdata_i};
                    if (st_r.due_size == SZ_BYTE) begin
                        st_nxt.core_rdata = {24'h000000, st_r.due_lane[0] ?
                            flash_module_rdata_i[15:8] : flash_module_rdata_i[7:0]};
                    end
                end
                default: begin
                    case (st_r.due_size)
                        SZ_BYTE: st_nxt.core_rdata = {24'h000000, st_r.due_lane[0] ?
                            ram_rdata_i[15:8] : ram_rdata_i[7:0]};
                        SZ_LONG: st_nxt.core_rdata = ram_rdata_i;
                        default: st_nxt.core_rdata = {16'h0000, ram_rdata_i[15:0]};
                    endcase
                end
            endcase
        end

        st_nxt.ram2_rd = sec_rd_i;
        if (sec_rd_i) begin
            st_nxt.ram2_addr = second_addr_bus_i;
        end
        st_nxt.sec_data_due = st_r.ram2_rd;

        st_nxt.timer_in = alt_trigger_mode_i && pwm_reload_i;
        st_nxt.adc_start = timer_chan_out_i;
    end

    // One register stage holds the fabric state, apart from the secondary and program return registers.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.fl_rd_n <= 1'b1;
            st_r.fl_wr_n <= 1'b1;
            st_r.rd_tgt <= TGT_RAM;
            st_r.rd_size <= SZ_WORD;
            st_r.due_tgt <= TGT_RAM;
            st_r.due_size <= SZ_WORD;
        end else begin
            st_r <= st_nxt;
        end
    end

    read_return_reg #(
        .W(NARROW_DW)
    ) u_sec_ret (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .cap_i(st_r.sec_data_due),
        .data_i(ram2_rdata_i),
        .data_o(sec_ret_data),
        .valid_o(sec_ret_valid)
    );

    read_return_reg #(
        .W(NARROW_DW)
    ) u_prog_ret (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .cap_i(st_r.prog_data_due),
        .data_i(pmem_rdata_i),
        .data_o(prog_ret_data),
        .valid_o(prog_ret_valid)
    );

    // Every output is a flop of the state or of a return register.
    assign prog_rdata_o = prog_ret_data;
    assign prog_rvalid_o = prog_ret_valid;
    assign core_rdata_o = st_r.core_rdata;
    assign core_rvalid_o = st_r.core_rvalid;
    assign second_read_bus_o = sec_ret_data;
    assign second_rvalid_o = sec_ret_valid;
    assign pmem_addr_o = st_r.pmem_addr;
    assign pmem_rd_o = st_r.pmem_rd;
    assign pmem_wr_o = st_r.pmem_wr;
    assign pmem_wdata_o = st_r.pmem_wdata;
    assign ram_addr_o = st_r.ram_addr;
    assign ram_rd_o = st_r.ram_rd;
    assign ram_wr_o = st_r.ram_wr;
    assign ram_be_o = st_r.ram_be;
    assign ram_wdata_o = st_r.ram_wdata;
    assign ram2_addr_o = st_r.ram2_addr;
    assign ram2_rd_o = st_r.ram2_rd;
    assign flash_module_addr_o = st_r.fl_addr;
    assign flash_module_rd_n_o = st_r.fl_rd_n;
    assign flash_module_wr_n_o = st_r.fl_wr_n;
    assign flash_module_wdata_o = st_r.fl_wdata;
    assign peripheral_bus_addr_o = st_r.pb_addr;
    assign peripheral_bus_rd_o = st_r.pb_rd;
    assign peripheral_bus_wr_o = st_r.pb_wr;
    assign peripheral_bus_wdata_o = st_r.pb_wdata;
    assign timer_chan_in_o = st_r.timer_in;
    assign adc_start_o = st_r.adc_start;

endmodule
`default_nettype wire

// [tb/fabric_target_model.sv]
`timescale 1ns/10ps
`default_nettype none
module fabric_target_model (
    // Clock.
    input wire logic clk_i,
    // Strobes and addresses from the fabric.
    input wire logic p_rd_i,
    input wire logic [20:0] p_a_i,
    input wire logic r_rd_i,
    input wire logic [23:0] r_a_i,
    input wire logic s_rd_i,
    input wire logic [23:0] s_a_i,
    input wire logic f_rd_n_i,
    input wire logic [23:0] f_a_i,
    input wire logic b_rd_i,
    input wire logic [23:0] b_a_i,
    // Read data, good only in the cycle after its strobe.
    output logic [15:0] p_d_o,
    output logic [31:0] r_d_o,
    output logic [15:0] s_d_o,
    output logic [15:0] f_d_o,
    output logic [15:0] b_d_o
);
    // Outside the answer cycle each bus flips every cycle, so a sample
    // taken a cycle early or late never matches by chance.
    initial {p_d_o, r_d_o, s_d_o, f_d_o, b_d_o} = '0;
    always @(posedge clk_i) begin
        p_d_o <= p_rd_i ? p_a_i[15:0] ^ 16'h5A5A : ~p_d_o;
        r_d_o <= r_rd_i ? {~r_a_i[15:0], r_a_i[15:0]} : ~r_d_o;
        s_d_o <= s_rd_i ? s_a_i[15:0] ^ 16'h3C3C : ~s_d_o;
        f_d_o <= !f_rd_n_i ? f_a_i[15:0] ^ 16'h0F0F : ~f_d_o;
        b_d_o <= b_rd_i ? b_a_i[15:0] ^ 16'hF00F : ~b_d_o;
    end
endmodule
`default_nettype wire

// [tb/fabric_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module fabric_chk
    import fabric_pkg::*;
(
    // Watched ports.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic prog_rd_i,
    input wire logic prog_wr_i,
    input wire logic [31:0] core_wdata_i,
    input wire logic [23:0] primary_data_addr_bus_i,
    input wire logic data_rd_i,
    input wire logic data_wr_i,
    input wire logic [1:0] data_size_i,
    input wire logic sec_rd_i,
    input wire logic [23:0] second_addr_bus_i,
    input wire logic prog_rvalid_o,
    input wire logic [31:0] core_rdata_o,
    input wire logic core_rvalid_o,
    input wire logic [15:0] second_read_bus_o,
    input wire logic second_rvalid_o,
    input wire logic pmem_rd_o,
    input wire logic pmem_wr_o,
    input wire logic [15:0] pmem_wdata_o,
    input wire logic [23:0] ram_addr_o,
    input wire logic [31:0] ram_rdata_i,
    input wire logic ram2_rd_o,
    input wire logic [23:0] ram2_addr_o,
    input wire logic [15:0] ram2_rdata_i,
    input wire logic flash_module_rd_n_o,
    input wire logic [15:0] flash_module_rdata_i,
    input wire logic peripheral_bus_rd_o,
    input wire logic [15:0] peripheral_bus_rdata_i,
    input wire logic alt_trigger_mode_i,
    input wire logic pwm_reload_i,
    input wire logic timer_chan_in_o,
    input wire logic timer_chan_out_i,
    input wire logic adc_start_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Helpers: target region, a plain read, low write half, byte word address.
    logic [11:0] rgn;
    logic rd_only;
    logic [15:0] wlow;
    logic [23:0] byte_word;
    assign rgn = primary_data_addr_bus_i[23:12];
    assign rd_only = data_rd_i && !data_wr_i;
    assign wlow = core_wdata_i[15:0];
    assign byte_word = {2'h0, primary_data_addr_bus_i[22:1]};

    // Multi-step answers of the program and secondary paths.
    sequence prog_answer;
        pmem_rd_o ##2 prog_rvalid_o;
    endsequence
    sequence sec_answer;
        ram2_rd_o && ram2_addr_o == $past(second_addr_bus_i) ##2
            second_rvalid_o && second_read_bus_o == $past(ram2_rdata_i);
    endsequence

    prog_fetch_a: assert property (prog_rd_i && !prog_wr_i |=> prog_answer)
        else $error("program read not answered on time");
    prog_write_a: assert property (prog_wr_i |=> pmem_wr_o && pmem_wdata_o == $past(wlow))
        else $error("program write data is not the low write half");
    long_read_a: assert property (rd_only && data_size_i == 2'h2 && rgn == 12'h000
        |=> ##2 core_rvalid_o && core_rdata_o == $past(ram_rdata_i))
        else $error("long read data not returned");
    byte_msb_a: assert property (data_wr_i && data_size_i == 2'h0
        && primary_data_addr_bus_i[22:13] == 10'h000 |=> ram_addr_o == $past(byte_word))
        else $error("byte address top bit not cleared");
    sec_read_a: assert property (sec_rd_i |=> sec_answer)
        else $error("secondary read not answered");
    per_read_a: assert property (rd_only && |data_size_i && rgn == PERIPH_REGION
        |=> peripheral_bus_rd_o
        ##2 core_rvalid_o && core_rdata_o[15:0] == $past(peripheral_bus_rdata_i))
        else $error("peripheral read added delay or lost data");
    flash_read_a: assert property (rd_only && |data_size_i && rgn == FLASH_REGION
        |=> !flash_module_rd_n_o
        ##2 core_rvalid_o && core_rdata_o[15:0] == $past(flash_module_rdata_i))
        else $error("flash read not passed to the core");
    reload_route_a: assert property (pwm_reload_i |=> timer_chan_in_o == $past(alt_trigger_mode_i))
        else $error("reload routing ignores the trigger mode");
    adc_start_a: assert property (timer_chan_out_i |=> adc_start_o)
        else $error("timer output did not start the converter");
endmodule
`default_nettype wire

// [tb/tb_core_system_bus_fabric.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_core_system_bus_fabric;
    import fabric_pkg::*;
    // Core side and trigger inputs.
    logic ref_clk_i = 1'b0, rst_i = 1'b1, prog_rd_i = 1'b0, prog_wr_i = 1'b0;
    logic data_rd_i = 1'b0, data_wr_i = 1'b0, sec_rd_i = 1'b0, alt_trigger_mode_i = 1'b0;
    logic pwm_reload_i = 1'b0, timer_chan_out_i = 1'b0;
    logic [1:0] data_size_i = 2'h0;
    logic [20:0] prog_addr_i = 21'h000000;
    logic [23:0] primary_data_addr_bus_i = 24'h000000, second_addr_bus_i = 24'h000000;
    logic [31:0] core_wdata_i = 32'h00000000;
    // Fabric outputs and target read data.
    logic [15:0] prog_rdata_o, second_read_bus_o, pmem_wdata_o, pmem_rdata_i;
    logic [15:0] ram2_rdata_i, flash_module_wdata_o, flash_module_rdata_i;
    logic [15:0] peripheral_bus_wdata_o, peripheral_bus_rdata_i;
    logic [31:0] core_rdata_o, ram_wdata_o, ram_rdata_i;
    logic [23:0] ram_addr_o, ram2_addr_o, flash_module_addr_o, peripheral_bus_addr_o;
    logic [20:0] pmem_addr_o;
    logic [3:0] ram_be_o;
    logic prog_rvalid_o, core_rvalid_o, second_rvalid_o, pmem_rd_o, pmem_wr_o, ram_rd_o;
    logic ram_wr_o, ram2_rd_o, flash_module_rd_n_o, flash_module_wr_n_o;
    logic peripheral_bus_rd_o, peripheral_bus_wr_o, timer_chan_in_o, adc_start_o;
    int fail_count = 0, num_checks = 0;

    // A 10 MHz clock.
    always #50 ref_clk_i = ~ref_clk_i;

    core_system_bus_fabric i_dut (.*);
    fabric_target_model i_mem (.clk_i(ref_clk_i), .p_rd_i(pmem_rd_o), .p_a_i(pmem_addr_o),
        .r_rd_i(ram_rd_o), .r_a_i(ram_addr_o), .s_rd_i(ram2_rd_o), .s_a_i(ram2_addr_o),
        .f_rd_n_i(flash_module_rd_n_o), .f_a_i(flash_module_addr_o),
        .b_rd_i(peripheral_bus_rd_o), .b_a_i(peripheral_bus_addr_o),
        .p_d_o(pmem_rdata_i), .r_d_o(ram_rdata_i), .s_d_o(ram2_rdata_i),
        .f_d_o(flash_module_rdata_i), .b_d_o(peripheral_bus_rdata_i));

    // Compares a seen value with the expected one.
    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Drops every request half a cycle after the edge that took it.
    task automatic step();
        @(negedge ref_clk_i);
        {prog_rd_i, prog_wr_i, data_rd_i, data_wr_i, sec_rd_i} = 5'h00;
        {pwm_reload_i, timer_chan_out_i} = 2'h0;
    endtask

    // Moves to just after the edge where a read answer shows.
    task automatic ans();
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask

    // Presents one primary request at the next falling edge.
    task automatic pri(input logic rd, input logic [1:0] sz, input logic [23:0] a,
        input logic [31:0] d);
        @(negedge ref_clk_i);
        data_rd_i = rd;
        data_wr_i = !rd;
        data_size_i = sz;
        primary_data_addr_bus_i = a;
        core_wdata_i = d;
    endtask

    // Program read, then write and read together so the write must win.
    task automatic t_prog();
        @(negedge ref_clk_i);
        prog_addr_i = 21'h1ABCDE;
        prog_rd_i = 1'b1;
        step();
        chk("pmem_addr", {pmem_rd_o, pmem_addr_o}, {1'b1, 21'h1ABCDE});
        ans();
        chk("prog_rdata", {prog_rvalid_o, prog_rdata_o}, {1'b1, 16'hE684});
        @(negedge ref_clk_i);
        {prog_rd_i, prog_wr_i} = 2'h3;
        core_wdata_i = 32'hDEADBEEF;
        step();
        chk("pmem_wr", {pmem_wr_o, pmem_rd_o, pmem_wdata_o}, {2'h2, 16'hBEEF});
    endtask

    // Long read followed at once by a long write.
    task automatic t_long();
        pri(1'b1, 2'h2, 24'h000123, 32'h0);
        pri(1'b0, 2'h2, 24'h000123, 32'h12345678);
        chk("ram_rd", {ram_rd_o, ram_be_o, ram_addr_o}, {1'b1, 4'hF, 24'h000123});
        step();
        chk("ram_wr", {ram_wr_o, ram_be_o, ram_wdata_o}, {5'h1F, 32'h12345678});
        @(posedge ref_clk_i);
        #1;
        chk("core_rdata", {core_rvalid_o, core_rdata_o}, {1'b1, 32'hFEDC0123});
    endtask

    // Byte write and read with the top address bit set.
    task automatic t_byte();
        pri(1'b0, 2'h0, 24'h800205, 32'h000000A7);
        pri(1'b1, 2'h0, 24'h800204, 32'h0);
        chk("byte_wr", {ram_wr_o, ram_be_o, ram_addr_o}, {1'b1, 4'h2, 24'h000102});
        chk("byte_lane", ram_wdata_o[15:8], 8'hA7);
        step();
        chk("byte_rd", {ram_rd_o, ram_be_o, ram_addr_o}, {1'b1, 4'h1, 24'h000102});
        ans();
        chk("byte_rdata", {core_rvalid_o, core_rdata_o}, {1'b1, 32'h00000002});
    endtask

    // Primary and secondary reads in the same cycle.
    task automatic t_dual();
        pri(1'b1, 2'h2, 24'h000200, 32'h0);
        sec_rd_i = 1'b1;
        second_addr_bus_i = 24'h000300;
        step();
        chk("dual_rd", {ram_rd_o, ram2_rd_o, ram2_addr_o}, {2'h3, 24'h000300});
        ans();
        chk("dual_vld", {core_rvalid_o, second_rvalid_o}, 2'h3);
        chk("second_read", second_read_bus_o, 16'h3F3C);
        chk("first_read", core_rdata_o, 32'hFDFF0200);
    endtask

    // Peripheral write then read, back to back.
    task automatic t_per();
        pri(1'b0, 2'h1, 24'h00F010, 32'h5555ABCD);
        pri(1'b1, 2'h1, 24'h00F020, 32'h0);
        chk("per_wr", {peripheral_bus_wr_o, ram_wr_o, peripheral_bus_wdata_o}, {2'h2, 16'hABCD});
        step();
        chk("per_rd", {peripheral_bus_rd_o, ram_rd_o, peripheral_bus_addr_o},
            {2'h2, 24'h00F020});
        ans();
        chk("per_rdata", {core_rvalid_o, core_rdata_o[15:0]}, {1'b1, 16'h002F});
    endtask

    // Flash array read then write; the strobes are active low.
    task automatic t_flash();
        pri(1'b1, 2'h1, 24'h004100, 32'h0);
        pri(1'b0, 2'h1, 24'h004102, 32'h00009876);
        chk("fl_rd", {flash_module_rd_n_o, peripheral_bus_rd_o, ram_rd_o, flash_module_addr_o},
            {3'h0, 24'h004100});
        step();
        chk("fl_wr", {flash_module_wr_n_o, flash_module_rd_n_o, flash_module_wdata_o},
            {2'h1, 16'h9876});
        @(posedge ref_clk_i);
        #1;
        chk("fl_rdata", {core_rvalid_o, core_rdata_o[15:0]}, {1'b1, 16'h4E0F});
    endtask

    // Long RAM read straight before a peripheral byte read on the upper lane:
    // each answer must keep the format of its own request.
    task automatic t_mix();
        pri(1'b1, 2'h2, 24'h000040, 32'h0);
        pri(1'b1, 2'h0, 24'h01E6B5, 32'h0);
        step();
        @(posedge ref_clk_i);
        #1;
        chk("mix_long", {core_rvalid_o, core_rdata_o}, {1'b1, 32'hFFBF0040});
        @(posedge ref_clk_i);
        #1;
        chk("mix_byte", {core_rvalid_o, core_rdata_o}, {1'b1, 32'h00000003});
    endtask

    // Reload pulse in both trigger modes, timer output in the second.
    task automatic t_trig();
        for (int m = 0; m < 2; m++) begin
            @(negedge ref_clk_i);
            alt_trigger_mode_i = m[0];
            pwm_reload_i = 1'b1;
            timer_chan_out_i = m[0];
            step();
            chk("chan_in", timer_chan_in_o, m[0]);
            chk("adc_start", adc_start_o, m[0]);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // The tests need under 100 cycles; a thousand means a hang.
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end

    // Reset for six cycles, then every scenario in turn.
    initial begin
        repeat (6) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        chk("idle", {flash_module_rd_n_o, flash_module_wr_n_o, ram_rd_o, core_rvalid_o}, 4'hC);
        t_prog();
        t_long();
        t_byte();
        t_dual();
        t_per();
        t_flash();
        t_mix();
        t_trig();
        complete_run();
    end
endmodule

bind core_system_bus_fabric fabric_chk i_chk (.*);
`default_nettype wire
